// ==== verilog/pmwc_top.sv ====
// Power mode and wake-up controller
`timescale 1ns/1ns
module pmwc_top import pmwc_pkg::*; (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Register port
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Core events
	input wire logic HALT,
	input wire logic WAKE,
	input wire logic WDT_WAKE,
	input wire logic CLR_WDT,
	// Oscillator pins
	input wire logic HOSC_PIN,
	input wire logic LOSC_PIN,
	// Clock controls
	output logic HOSC_EN,
	output logic LOSC_EN,
	output logic SYS_CLK_EN,
	output logic SYS_LOW,
	output logic [2:0] SYS_DIV,
	output logic DIV16_TICK,
	output logic DIV64_TICK,
	output logic TBC_EN,
	output logic WDT_CLK_EN,
	output logic WDT_CLR,
	output logic CPU_RUN
);
	pmwc_state_t state_q, state_d, halt_tgt;
	logic [7:0] mode_q;
	logic keep_q;
	logic [3:0] cfg_q;
	logic pdf_q;
	logic to_q;
	logic [1:0] fcnt_q;
	logic [5:0] div_q;
	logic h_tick, l_tick, hrdy, lrdy;
	logic sel_low, wdt_on, lvd_on, run_st, halt_take, wake_any, fast_ok;
	logic hosc_d, losc_d;

	assign wdt_on = cfg_q[FB_WDT];
	assign lvd_on = cfg_q[FB_LVD];
	assign sel_low = !mode_q[MB_HCLK] && (mode_q[MB_DIV+:3] <= DIV_LOW_MAX);
	assign run_st = state_q inside {ST_NORMAL, ST_SLOW, ST_FAST};
	assign halt_take = HALT && run_st;
	assign wake_any = WAKE || WDT_WAKE;
	// Fast wake needs crystal high source, high target and a live low clock
	assign fast_ok = mode_q[MB_FAST] && !cfg_q[FB_HRC] && !sel_low
		&& (state_q == ST_GIDLE || (state_q == ST_WSLEEP && wdt_on));

	pmwc_sync u_hsync (.clk(CLK), .rst(RST), .pin(HOSC_PIN), .rise(h_tick));
	pmwc_sync u_lsync (.clk(CLK), .rst(RST), .pin(LOSC_PIN), .rise(l_tick));
	pmwc_cnt u_hcnt (
		.clk(CLK), .rst(RST), .en(HOSC_EN), .tick(h_tick),
		.limit(cfg_q[FB_HRC] ? HIGH_SPEED_RC_CNT : HXT_CNT),
		.done(hrdy)
	);
	pmwc_cnt u_lcnt (
		.clk(CLK), .rst(RST), .en(LOSC_EN), .tick(l_tick),
		.limit(cfg_q[FB_LXT] ? LXT_CNT : LOW_SPEED_RC_CNT),
		.done(lrdy)
	);

	// Low-power target on a halt
	always_comb begin
		if (mode_q[MB_IDLE]) begin
			halt_tgt = keep_q ? ST_CIDLE : ST_GIDLE;
		end else if (wdt_on || lvd_on) begin
			halt_tgt = ST_WSLEEP;
		end else begin
			halt_tgt = ST_DEEP;
		end
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_NORMAL: begin
				if (halt_take) begin
					state_d = halt_tgt;
				end else if (sel_low && lrdy) begin
					state_d = ST_SLOW;
				end
			end
			ST_SLOW: begin
				if (halt_take) begin
					state_d = halt_tgt;
				end else if (!sel_low && hrdy) begin
					state_d = ST_NORMAL;
				end
			end
			ST_FAST: begin
				if (halt_take) begin
					state_d = halt_tgt;
				end else if (hrdy) begin
					state_d = ST_NORMAL;
				end
			end
			ST_DEEP, ST_WSLEEP, ST_GIDLE, ST_CIDLE: begin
				if (wake_any) begin
					state_d = fast_ok ? ST_FWAIT : ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (sel_low ? lrdy : hrdy) begin
					state_d = sel_low ? ST_SLOW : ST_NORMAL;
				end
			end
			ST_FWAIT: begin
				if (l_tick && fcnt_q == FAST_CNT - 2'h1) begin
					state_d = ST_FAST;
				end
			end
			default: state_d = ST_NORMAL;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_q <= ST_NORMAL;
		end else begin
			state_q <= state_d;
		end
	end

	// Low clock cycles counted while the fast wake is pending
	always_ff @(posedge CLK) begin
		if (RST || state_q != ST_FWAIT) begin
			fcnt_q <= 2'h0;
		end else if (l_tick) begin
			fcnt_q <= fcnt_q + 2'h1;
		end
	end

	// Oscillator demand follows the next state
	always_comb begin
		hosc_d = 1'b0;
		losc_d = 1'b0;
		unique case (state_d)
			ST_NORMAL, ST_FAST, ST_CIDLE, ST_FWAIT: hosc_d = 1'b1;
			ST_SLOW, ST_WAKE: hosc_d = !sel_low;
			default: hosc_d = 1'b0;
		endcase
		unique case (state_d)
			ST_DEEP: losc_d = 1'b0;
			ST_GIDLE, ST_CIDLE, ST_FWAIT, ST_FAST: losc_d = 1'b1;
			default: losc_d = wdt_on || sel_low;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			HOSC_EN <= 1'b1;
			LOSC_EN <= 1'b1;
			SYS_CLK_EN <= 1'b1;
			SYS_LOW <= 1'b0;
			TBC_EN <= 1'b1;
			WDT_CLK_EN <= 1'b1;
			CPU_RUN <= 1'b1;
		end else begin
			HOSC_EN <= hosc_d;
			LOSC_EN <= losc_d;
			SYS_CLK_EN <= state_d inside {ST_NORMAL, ST_SLOW, ST_FAST, ST_CIDLE};
			SYS_LOW <= state_d inside {ST_SLOW, ST_FAST};
			TBC_EN <= state_d inside {ST_NORMAL, ST_SLOW, ST_FAST, ST_GIDLE, ST_CIDLE};
			WDT_CLK_EN <= wdt_on && state_d != ST_DEEP;
			CPU_RUN <= state_d inside {ST_NORMAL, ST_SLOW, ST_FAST};
		end
	end

	// Watchdog cleared on every halt entry
	always_ff @(posedge CLK) begin
		if (RST) begin
			WDT_CLR <= 1'b0;
		end else begin
			WDT_CLR <= halt_take;
		end
	end

	// Divided high clock ticks, silent while the high source is off
	always_ff @(posedge CLK) begin
		if (RST || !HOSC_EN) begin
			div_q <= '0;
			DIV16_TICK <= 1'b0;
			DIV64_TICK <= 1'b0;
		end else begin
			if (h_tick) begin
				div_q <= div_q + 6'h01;
			end
			DIV16_TICK <= h_tick && (div_q & DIV16_MASK) == DIV16_MASK;
			DIV64_TICK <= h_tick && div_q == DIV64_MASK;
		end
	end

	// Power-down and timeout flags; set wins over clear
	always_ff @(posedge CLK) begin
		if (RST) begin
			pdf_q <= 1'b0;
			to_q <= 1'b0;
		end else begin
			if (halt_take) begin
				pdf_q <= 1'b1;
			end else if (CLR_WDT) begin
				pdf_q <= 1'b0;
			end
			if (WDT_WAKE) begin
				to_q <= 1'b1;
			end else if (halt_take) begin
				to_q <= 1'b0;
			end
		end
	end

	// Register writes
	always_ff @(posedge CLK) begin
		if (RST) begin
			mode_q <= MODE_RST;
			keep_q <= 1'b0;
			cfg_q <= CFG_RST[3:0];
		end else if (WR) begin
			if (ADDR == PMWC_A_MODE) begin
				mode_q <= WDATA;
			end
			if (ADDR == PMWC_A_CTRL) begin
				keep_q <= WDATA[CB_KEEP];
			end
			if (ADDR == PMWC_A_CFG) begin
				cfg_q <= WDATA[3:0];
			end
		end
	end

	assign SYS_DIV = mode_q[MB_DIV+:3];

	// Register reads, data in the following cycle
	always_ff @(posedge CLK) begin
		if (RST) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			unique case (ADDR)
				PMWC_A_MODE: RDATA <= {mode_q[7:4], lrdy, hrdy, mode_q[1:0]};
				PMWC_A_CTRL: RDATA <= {keep_q, 7'h00};
				PMWC_A_STAT: RDATA <= {2'h0, state_q, to_q, pdf_q};
				PMWC_A_CFG: RDATA <= {4'h0, cfg_q};
				default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	a_fast_entry_src: assert property ((state_q != ST_FWAIT && state_d == ST_FWAIT)
		|-> state_q inside {ST_WSLEEP, ST_GIDLE}) else $error("fast wake from wrong state");
	a_deep_no_fast: assert property (state_q == ST_DEEP |=> state_q != ST_FWAIT)
		else $error("fast wake taken from deep sleep");
	a_fast_runs_low: assert property (state_q == ST_FAST |-> SYS_LOW && CPU_RUN)
		else $error("fast run not on low clock");
	a_fast_exit_rdy: assert property ((state_q == ST_FAST && state_d == ST_NORMAL) |-> hrdy)
		else $error("left fast run before high ready");
	a_rc_no_fast: assert property (cfg_q[FB_HRC] |-> state_d != ST_FWAIT || state_q == ST_FWAIT)
		else $error("fast wake with RC source");
	a_slow_hosc_off: assert property ((state_q == ST_SLOW && sel_low)[*2]
		|-> !HOSC_EN && !DIV16_TICK && !DIV64_TICK) else $error("high clock left running");
	a_slow_needs_rdy: assert property ((state_q == ST_NORMAL && state_d == ST_SLOW) |-> lrdy)
		else $error("slow switch before low ready");
	a_deep_cond: assert property ((run_st && state_d == ST_DEEP)
		|-> !mode_q[MB_IDLE] && !wdt_on && !lvd_on) else $error("deep sleep entry illegal");
	a_deep_clocks: assert property (state_q == ST_DEEP
		|-> !WDT_CLK_EN && !TBC_EN && !SYS_CLK_EN && !LOSC_EN) else $error("clock alive in deep sleep");
	a_gidle_clocks: assert property (state_q == ST_GIDLE |-> !SYS_CLK_EN && TBC_EN && LOSC_EN)
		else $error("gated idle clocks wrong");
	a_cidle_clocks: assert property (state_q == ST_CIDLE
		|-> SYS_CLK_EN && TBC_EN && LOSC_EN && !CPU_RUN) else $error("clocked idle clocks wrong");
	a_halt_effects: assert property (halt_take |=> WDT_CLR && pdf_q && !CPU_RUN)
		else $error("halt entry effects missing");
	a_hrdy_cleared: assert property ((state_q inside {ST_WSLEEP, ST_GIDLE, ST_DEEP})[*2] |-> !hrdy)
		else $error("high ready not cleared asleep");
	c_fast_wake: cover property (state_q == ST_FWAIT ##[1:1000] state_q == ST_FAST);
	c_slow_mode: cover property (state_q == ST_NORMAL ##1 state_q == ST_SLOW);
	c_deep_wake: cover property (state_q == ST_DEEP ##1 state_q == ST_WAKE);
	c_cidle: cover property (state_q == ST_CIDLE);
endmodule : pmwc_top

// ==== include/pmwc_pkg.sv ====
// Constants and types for the power mode and wake-up controller
package pmwc_pkg;
	localparam logic [3:0] PMWC_A_MODE = 4'h0;
	localparam logic [3:0] PMWC_A_CTRL = 4'h1;
	localparam logic [3:0] PMWC_A_STAT = 4'h2;
	localparam logic [3:0] PMWC_A_CFG = 4'h3;
	localparam int MB_HCLK = 0;
	localparam int MB_IDLE = 1;
	localparam int MB_HRDY = 2;
	localparam int MB_LRDY = 3;
	localparam int MB_FAST = 4;
	localparam int MB_DIV = 5;
	localparam int CB_KEEP = 7;
	localparam int SB_PDF = 0;
	localparam int SB_TO = 1;
	localparam int SB_ST = 2;
	localparam int FB_HRC = 0;
	localparam int FB_LXT = 1;
	localparam int FB_WDT = 2;
	localparam int FB_LVD = 3;
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] CFG_RST = 8'h04;
	localparam logic [2:0] DIV_LOW_MAX = 3'h1;
	localparam int CW = 10;
	localparam logic [CW-1:0] HXT_CNT = 10'h200;
	localparam logic [CW-1:0] HIGH_SPEED_RC_CNT = 10'h010;
	localparam logic [CW-1:0] LXT_CNT = 10'h080;
	localparam logic [CW-1:0] LOW_SPEED_RC_CNT = 10'h002;
	localparam logic [1:0] FAST_CNT = 2'h2;
	localparam logic [5:0] DIV16_MASK = 6'h0F;
	localparam logic [5:0] DIV64_MASK = 6'h3F;
	typedef enum logic [3:0] {
		ST_NORMAL = 4'b0000,
		ST_SLOW = 4'b0001,
		ST_DEEP = 4'b0010,
		ST_WSLEEP = 4'b0011,
		ST_GIDLE = 4'b0100,
		ST_CIDLE = 4'b0101,
		ST_WAKE = 4'b0110,
		ST_FWAIT = 4'b0111,
		ST_FAST = 4'b1000
	} pmwc_state_t;
endpackage : pmwc_pkg

// ==== verilog/pmwc_sync.sv ====
// Two-stage synchroniser with rising-edge pulse
`timescale 1ns/1ns
module pmwc_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin in, edge out
	input wire logic pin,
	output logic rise
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign rise = s2_q & ~s3_q;
endmodule : pmwc_sync

// ==== verilog/pmwc_cnt.sv ====
// Oscillator stabilisation counter with ready flag
`timescale 1ns/1ns
module pmwc_cnt import pmwc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Oscillator running and its cycle ticks
	input wire logic en,
	input wire logic tick,
	input wire logic [CW-1:0] limit,
	// Stable flag
	output logic done
);
	logic [CW-1:0] cnt_q;
	always_ff @(posedge clk) begin
		if (rst || !en) begin
			cnt_q <= '0;
			done <= 1'b0;
		end else if (tick && !done) begin
			cnt_q <= cnt_q + 1'b1;
			done <= (cnt_q + 1'b1) == limit;
		end
	end
endmodule : pmwc_cnt

// ==== test/pmwc_osc_model.sv ====
// Oscillator model driving a clock pin only while enabled
`timescale 1ns/1ns
module pmwc_osc_model #(
	parameter int HALF = 7
) (
	// Enable in, clock pin out
	input wire logic en,
	output logic pin
);
	initial begin
		pin = 1'h0;
		forever begin
			#HALF;
			pin = en ? ~pin : 1'h0;
		end
	end
endmodule : pmwc_osc_model

// ==== test/pmwc_tb_top.sv ====
// Self-checking bench for the power mode and wake-up controller
`timescale 1ns/1ns
module pmwc_tb_top;
	import pmwc_pkg::*;
	logic clk, rst, wr, rd, halt, wake, wdt_wake, clr_wdt, rd_d, t;
	logic hosc_en, losc_en, sys_clk_en, sys_low, div16, div64, tbc_en, wdt_clk_en, wdt_clr, cpu_run, hpin, lpin;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, rv;
	logic [2:0] sys_div;
	logic [7:0] expq[$];
	int n_mismatch, cmp_count, waited, i, j, seed;

	pmwc_top dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.HALT(halt), .WAKE(wake), .WDT_WAKE(wdt_wake), .CLR_WDT(clr_wdt), .HOSC_PIN(hpin), .LOSC_PIN(lpin),
		.HOSC_EN(hosc_en), .LOSC_EN(losc_en), .SYS_CLK_EN(sys_clk_en), .SYS_LOW(sys_low), .SYS_DIV(sys_div),
		.DIV16_TICK(div16), .DIV64_TICK(div64), .TBC_EN(tbc_en), .WDT_CLK_EN(wdt_clk_en), .WDT_CLR(wdt_clr),
		.CPU_RUN(cpu_run));
	pmwc_osc_model #(.HALF(7)) hosc (.en(hosc_en), .pin(hpin));
	pmwc_osc_model #(.HALF(23)) losc (.en(losc_en), .pin(lpin));

	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] ex);
		cmp_count++;
		if (seen !== ex) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, seen);
		end
	endtask : chk

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	function automatic logic [7:0] st(input logic [3:0] s, input logic to, input logic pd);
		return {2'h0, s, to, pd};
	endfunction : st

	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wreg

	// Note the expected value; the monitor compares it two cycles later
	task automatic rreg(input logic [3:0] a, input logic [7:0] ex);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		expq.push_back(ex);
		@(posedge clk);
		rd <= 1'h0;
		repeat (2) @(posedge clk);
	endtask : rreg

	// Bits: halt, wake, watchdog wake, clear watchdog
	task automatic pulse(input logic [3:0] w);
		@(posedge clk);
		{clr_wdt, wdt_wake, wake, halt} <= w;
		@(posedge clk);
		{clr_wdt, wdt_wake, wake, halt} <= 4'h0;
		#1;
	endtask : pulse

	task automatic wait_for(input int sel, input logic v);
		waited = 0;
		while ((sel == 0 ? cpu_run : sys_low) !== v && waited < 4000) begin
			@(posedge clk);
			#1;
			waited++;
		end
		chk("WAIT", 8'(sel == 0 ? cpu_run : sys_low), 8'(v));
	endtask : wait_for

	always @(posedge clk) begin
		rd_d <= rd;
		if (rd_d === 1'h1 && expq.size() > 0)
			chk("RDATA", rdata, expq.pop_front());
	end

	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end

	initial begin
		seed = 32'h895C;
		{rst, wr, rd, halt, wake, wdt_wake, clr_wdt} = 7'h40;
		addr = 4'h0;
		wdata = 8'h00;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		rreg(PMWC_A_CFG, 8'h04);
		rreg(PMWC_A_CTRL, 8'h00);
		rv = 8'($random(seed));
		wreg(4'h9, rv);
		rv = 8'($random(seed));
		wreg(PMWC_A_STAT, rv);
		rreg(4'h9, 8'h00);
		repeat (2000) @(posedge clk);
		rreg(PMWC_A_MODE, 8'h0D);
		rreg(PMWC_A_STAT, 8'h00);
		$display("test reset done");
		wreg(PMWC_A_CFG, 8'h00);
		wreg(PMWC_A_MODE, 8'h11);
		pulse(4'h1);
		chk("WDT_CLR", 8'(wdt_clr), 8'h01);
		chk("CLKS", {3'h0, losc_en, sys_clk_en, wdt_clk_en, tbc_en, cpu_run}, 8'h00);
		rreg(PMWC_A_STAT, st(ST_DEEP, 1'h0, 1'h1));
		pulse(4'h2);
		wait_for(0, 1'h1);
		chk("SYS_LOW", 8'(sys_low), 8'h00);
		chk("SLOW_WAKE", 8'(waited > 1000), 8'h01);
		$display("test deep done");
		wreg(PMWC_A_CFG, 8'h06);
		repeat (50) @(posedge clk);
		rreg(PMWC_A_MODE, 8'h15);
		pulse(4'h1);
		chk("WSLEEP", {4'h0, sys_clk_en, tbc_en, wdt_clk_en, wdt_clr}, 8'h03);
		rreg(PMWC_A_STAT, st(ST_WSLEEP, 1'h0, 1'h1));
		pulse(4'h4);
		wait_for(0, 1'h1);
		chk("SYS_LOW", 8'(sys_low), 8'h01);
		chk("FAST", 8'(waited < 100), 8'h01);
		wait_for(1, 1'h0);
		chk("SWITCH", 8'(waited > 1000), 8'h01);
		rreg(PMWC_A_STAT, st(ST_NORMAL, 1'h1, 1'h1));
		pulse(4'h8);
		rreg(PMWC_A_STAT, st(ST_NORMAL, 1'h1, 1'h0));
		$display("test wsleep done");
		wreg(PMWC_A_MODE, 8'h03);
		pulse(4'h1);
		chk("CLOCK_GATED_IDLE", {4'h0, sys_clk_en, tbc_en, losc_en, cpu_run}, 8'h06);
		rreg(PMWC_A_MODE, 8'h0B);
		rreg(PMWC_A_STAT, st(ST_GIDLE, 1'h0, 1'h1));
		pulse(4'h2);
		wait_for(0, 1'h1);
		chk("HRDY_WAIT", 8'(waited > 1000), 8'h01);
		wreg(PMWC_A_CTRL, 8'h80);
		pulse(4'h1);
		chk("CLOCKED_IDLE", {4'h0, sys_clk_en, tbc_en, losc_en, cpu_run}, 8'h0E);
		rreg(PMWC_A_STAT, st(ST_CIDLE, 1'h0, 1'h1));
		pulse(4'h2);
		wait_for(0, 1'h1);
		wreg(PMWC_A_CTRL, 8'h00);
		$display("test idle done");
		for (j = 0; j < 2; j++) begin
			wreg(PMWC_A_MODE, j == 0 ? 8'h00 : 8'h20);
			wait_for(1, 1'h1);
			chk("SYS_DIV", {5'h0, sys_div}, 8'(j));
			repeat (2) @(posedge clk);
			#1;
			chk("HOSC_EN", 8'(hosc_en), 8'h00);
			t = 1'h0;
			for (i = 0; i < 200; i++) begin
				@(posedge clk);
				#1;
				t = t | div16 | div64;
			end
			chk("TICKS", 8'(t), 8'h00);
			wreg(PMWC_A_MODE, j == 0 ? 8'h40 : 8'h01);
			wait_for(1, 1'h0);
			chk("HOSC_EN", 8'(hosc_en), 8'h01);
			rv = 8'h00;
			for (i = 0; i < 300; i++) begin
				@(posedge clk);
				#1;
				rv = rv | {6'h00, div16, div64};
			end
			chk("TICKS_ON", rv, 8'h03);
		end
		$display("test slow done");
		wreg(PMWC_A_CFG, 8'h05);
		wreg(PMWC_A_MODE, 8'h11);
		repeat (100) @(posedge clk);
		pulse(4'h9);
		pulse(4'h2);
		wait_for(0, 1'h1);
		chk("SYS_LOW", 8'(sys_low), 8'h00);
		chk("RC_WAKE", 8'(waited < 200), 8'h01);
		rreg(PMWC_A_STAT, st(ST_NORMAL, 1'h0, 1'h1));
		$display("test rc done");
		conclude();
	end
endmodule : pmwc_tb_top
